//--- hdl/vcd_pkg.sv
`default_nettype none
package vcd_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] A_CFG = 8'h00;
  localparam logic [7:0] A_START = 8'h04;
  localparam logic [7:0] A_XCNT = 8'h08;
  localparam logic [7:0] A_XMOD = 8'h0c;
  localparam logic [7:0] A_YCNT = 8'h10;
  localparam logic [7:0] A_YMOD = 8'h14;
  localparam logic [7:0] A_NDP = 8'h18;
  localparam logic [7:0] A_CUR = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;
  localparam logic [7:0] A_PCTL = 8'h24;
  localparam logic [7:0] A_PFRM = 8'h28;
  localparam logic [7:0] A_PSTAT = 8'h2c;
  // channel configuration fields
  localparam int CFG_EN = 0;
  localparam int CFG_WW = 1;
  localparam int CFG_FLOW = 4;
  localparam int CFG_ND = 8;
  localparam int CFG_DIR = 12;
  localparam int CFG_IE = 13;
  localparam logic [1:0] WW_8 = 2'h0;
  localparam logic [1:0] WW_16 = 2'h1;
  localparam logic [3:0] FLOW_LIST = 4'h6;
  // status and port control bits
  localparam int ST_DONE = 0;
  localparam int ST_OVR = 1;
  localparam int PC_EN = 0;
  localparam int PC_ITU = 1;
  localparam int PS_FTE = 0;
  // reset values
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] FRM_RST = 16'h020d;
  localparam logic [2:0] PCTL_RST = 3'h0;
  // dma channel serving the capture port
  localparam logic [3:0] DMA_MAP = 4'h0;
  // embedded sync code of the byte stream
  localparam logic [7:0] SYNC_FF = 8'hff;
  localparam logic [7:0] SYNC_00 = 8'h00;
  localparam int XY_H = 4;
  localparam int XY_V = 5;
  localparam int XY_F = 6;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_DESC = 3'b010,
    S_XFER = 3'b100
  } vcd_state_t;
endpackage
`default_nettype wire

//--- hdl/vcd_port.sv
`timescale 1ns/1ps
`default_nettype none
module vcd_port (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // decoder pins, foreign timing
  input wire logic vid_clk_i,
  input wire logic [7:0] vid_data_i,
  // settings from the register file
  input wire logic en_i,
  input wire logic itu_i,
  input wire logic [15:0] frame_lines_i,
  input wire logic ft_clr_i,
  // received bytes and status
  output logic [7:0] byte_o,
  output logic byte_vld_o,
  output logic frame_track_error_o
);
  logic ck1, ck2, ck3;
  logic [7:0] d1, d2;
  logic [23:0] h, next_h;
  logic act, next_act, fld, next_fld, seen, next_seen;
  logic [15:0] lines, next_lines;
  logic next_fte, next_vld, fr_end, vedge;
  logic [7:0] next_byte;
  localparam logic [7:0] SYNC_FF_W = vcd_pkg::SYNC_FF;
  localparam logic [7:0] SYNC_00_W = vcd_pkg::SYNC_00;

  // two flops per pin; ck3 only serves the edge finder
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ck1 <= 1'b0;
      ck2 <= 1'b0;
      ck3 <= 1'b0;
      d1 <= 8'h00;
      d2 <= 8'h00;
    end
    else
    begin
      ck1 <= vid_clk_i;
      ck2 <= ck1;
      ck3 <= ck2;
      d1 <= vid_data_i;
      d2 <= d1;
    end
  end

  assign vedge = ck2 & ~ck3;

  // stream parser; the clear comes first so a new error wins
  always_comb
  begin
    next_h = h;
    next_act = act;
    next_fld = fld;
    next_seen = seen;
    next_lines = lines;
    next_fte = frame_track_error_o;
    next_vld = 1'b0;
    next_byte = byte_o;
    fr_end = 1'b0;
    if (ft_clr_i)
      next_fte = 1'b0;
    if (vedge && en_i)
    begin
      next_h = {h[15:0], d2};
      if (!itu_i)
      begin
        next_vld = 1'b1;
        next_byte = d2;
      end
      else if (h == {SYNC_FF_W, SYNC_00_W, SYNC_00_W})
      begin
        if (!d2[vcd_pkg::XY_H])
          next_act = ~d2[vcd_pkg::XY_V];
        else
        begin
          next_act = 1'b0;
          next_fld = d2[vcd_pkg::XY_F];
          if (fld && !d2[vcd_pkg::XY_F])
          begin
            fr_end = 1'b1;
            next_seen = 1'b1;
            next_lines = 16'h0001;
            if (seen && lines != frame_lines_i)
              next_fte = 1'b1;
          end
          else
            next_lines = lines + 16'h0001;
        end
      end
      else if (d2 == vcd_pkg::SYNC_FF)
        next_act = 1'b0;
      else if (act)
      begin
        next_vld = 1'b1;
        next_byte = d2;
      end
    end
  end

  // parser registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      h <= 24'h000000;
      act <= 1'b0;
      fld <= 1'b0;
      seen <= 1'b0;
      lines <= 16'h0000;
      frame_track_error_o <= 1'b0;
      byte_vld_o <= 1'b0;
      byte_o <= 8'h00;
    end
    else
    begin
      h <= next_h;
      act <= next_act;
      fld <= next_fld;
      seen <= next_seen;
      lines <= next_lines;
      frame_track_error_o <= next_fte;
      byte_vld_o <= next_vld;
      byte_o <= next_byte;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ft_sticky: assert property (frame_track_error_o && !ft_clr_i |=> frame_track_error_o)
    else $error("frame track error dropped without a clear");
  chk_ft_set: assert property (fr_end && seen && lines != frame_lines_i
    |=> frame_track_error_o)
    else $error("line count mismatch not flagged");
  chk_sync_gap: assert property (itu_i && vedge && d2 == vcd_pkg::SYNC_FF
    |=> !byte_vld_o)
    else $error("sync byte passed as data");
endmodule
`default_nettype wire

//--- hdl/vcd_dma.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - inner and outer counts set how many words are moved; a count of zero moves one, as a count of one does
// - word width of 8, 16 or 32 bits chosen by configuration
// - address steps by the inner stride after each word, by the outer stride at a row end, and not after the last word
// - a next-descriptor pointer names the following descriptor
// - on enable, fetch the descriptor first, before any data moves; only done in list mode with a nonzero size
// - small list mode goes on to the next buffer by itself
// - four elements: pointer, address low, address high, configuration
// - configuration holds mode, width, size, direction, interrupt enable
// - with interrupts enabled, each finished buffer raises the interrupt
// - pointers are followed until a configuration with enable or list mode clear is loaded, so two descriptors can alternate
// - the capture port is served by channel zero by default
// - the port can take framing from codes embedded in the stream
// - the decoder sends 8 or 16 bits; the port takes eight
// - a line count unlike the frame length sets the frame track error
module vcd_dma (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone register slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // wishbone memory master
  output logic m_cyc_o,
  output logic m_stb_o,
  output logic m_we_o,
  output logic [31:0] m_adr_o,
  output logic [3:0] m_sel_o,
  output logic [31:0] m_dat_o,
  input wire logic m_ack_i,
  input wire logic [31:0] m_dat_i,
  // video decoder pins
  input wire logic vid_clk_i,
  input wire logic [7:0] vid_data_i,
  // buffer completion interrupt
  output logic irq_o
);
  // byte lanes of one word at an address
  function automatic logic [3:0] lane_sel(input logic [1:0] w,
                                          input logic [1:0] a);
    case (w)
      vcd_pkg::WW_8: lane_sel = 4'h1 << a;
      vcd_pkg::WW_16: lane_sel = a[1] ? 4'hc : 4'h3;
      default: lane_sel = 4'hf;
    endcase
  endfunction

  // index of the last byte in a word
  function automatic logic [1:0] last_byte(input logic [1:0] w);
    case (w)
      vcd_pkg::WW_8: last_byte = 2'h0;
      vcd_pkg::WW_16: last_byte = 2'h1;
      default: last_byte = 2'h3;
    endcase
  endfunction

  // byte-enable merge of a register write
  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
      merge[8*i +: 8] = s[i] ? n[8*i +: 8] : o[8*i +: 8];
  endfunction

  logic [15:0] cfg, next_cfg, xcnt, next_xcnt, xmod, next_xmod;
  logic [15:0] ycnt, next_ycnt, ymod, next_ymod, frm, next_frm;
  logic [15:0] xcur, next_xcur, ycur, next_ycur, ev;
  logic [31:0] start, next_start, ndp, next_ndp, fp, next_fp;
  logic [31:0] cur, next_cur, pack, next_pack, wdat, next_wdat, tmp;
  logic [31:0] cur_x, cur_y, next_rdat, next_madr, next_mdat;
  logic [1:0] elem, next_elem, pcnt, next_pcnt, ww;
  logic [3:0] flow, nd, next_msel;
  logic [2:0] pctl, next_pctl;
  logic wpend, next_wpend, done, next_done, ovr, next_ovr;
  logic halt, next_halt, next_mcyc, next_mwe, go, wr, rd, ft_clr;
  logic [7:0] pbyte;
  logic pvld, fte, listed;
  vcd_pkg::vcd_state_t st, next_st;

  assign ww = cfg[vcd_pkg::CFG_WW +: 2];
  assign flow = cfg[vcd_pkg::CFG_FLOW +: 4];
  assign nd = cfg[vcd_pkg::CFG_ND +: 4];
  assign listed = flow == vcd_pkg::FLOW_LIST && nd != 4'h0;
  assign wr = wb_cyc_i & wb_stb_i & ~wb_ack_o & wb_we_i;
  assign rd = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_we_i;
  assign ft_clr = wr && wb_adr_i == vcd_pkg::A_PSTAT && wb_sel_i[0]
    && wb_dat_i[vcd_pkg::PS_FTE];
  assign cur_x = cur + {{16{xmod[15]}}, xmod};
  assign cur_y = cur + {{16{ymod[15]}}, ymod};
  assign ev = fp[1] ? m_dat_i[31:16] : m_dat_i[15:0];

  // capture port; it feeds this channel, number zero
  vcd_port u_port (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .vid_clk_i(vid_clk_i),
    .vid_data_i(vid_data_i),
    .en_i(pctl[vcd_pkg::PC_EN]),
    .itu_i(pctl[vcd_pkg::PC_ITU]),
    .frame_lines_i(frm),
    .ft_clr_i(ft_clr),
    .byte_o(pbyte),
    .byte_vld_o(pvld),
    .frame_track_error_o(fte)
  );

  // register file and channel; hardware updates follow software ones
  always_comb
  begin
    next_cfg = cfg; next_start = start; next_xcnt = xcnt;
    next_xmod = xmod; next_ycnt = ycnt; next_ymod = ymod;
    next_ndp = ndp; next_fp = fp; next_cur = cur;
    next_xcur = xcur; next_ycur = ycur; next_elem = elem;
    next_pcnt = pcnt; next_pack = pack; next_wdat = wdat;
    next_wpend = wpend; next_done = done; next_ovr = ovr;
    next_halt = halt; next_pctl = pctl; next_frm = frm;
    next_st = st; next_mcyc = m_cyc_o; next_mwe = m_we_o;
    next_madr = m_adr_o; next_msel = m_sel_o; next_mdat = m_dat_o;
    next_rdat = wb_dat_o; go = 1'b0; tmp = 32'h0;
    // read answer, unmapped reads give zero
    if (rd)
      case (wb_adr_i)
        vcd_pkg::A_CFG: next_rdat = {16'h0, cfg};
        vcd_pkg::A_START: next_rdat = start;
        vcd_pkg::A_XCNT: next_rdat = {16'h0, xcnt};
        vcd_pkg::A_XMOD: next_rdat = {16'h0, xmod};
        vcd_pkg::A_YCNT: next_rdat = {16'h0, ycnt};
        vcd_pkg::A_YMOD: next_rdat = {16'h0, ymod};
        vcd_pkg::A_NDP: next_rdat = ndp;
        vcd_pkg::A_CUR: next_rdat = cur;
        vcd_pkg::A_STAT: next_rdat = {29'h0, st != vcd_pkg::S_IDLE, ovr, done};
        vcd_pkg::A_PCTL: next_rdat = {29'h0, pctl};
        vcd_pkg::A_PFRM: next_rdat = {16'h0, frm};
        vcd_pkg::A_PSTAT: next_rdat = {24'h0, vcd_pkg::DMA_MAP, 3'h0, fte};
        default: next_rdat = 32'h0;
      endcase
    if (wr)
      case (wb_adr_i)
        vcd_pkg::A_CFG: begin tmp = merge({16'h0, cfg}, wb_dat_i, wb_sel_i);
          next_cfg = tmp[15:0]; end
        vcd_pkg::A_START: next_start = merge(start, wb_dat_i, wb_sel_i);
        vcd_pkg::A_XCNT: begin tmp = merge({16'h0, xcnt}, wb_dat_i, wb_sel_i);
          next_xcnt = tmp[15:0]; end
        vcd_pkg::A_XMOD: begin tmp = merge({16'h0, xmod}, wb_dat_i, wb_sel_i);
          next_xmod = tmp[15:0]; end
        vcd_pkg::A_YCNT: begin tmp = merge({16'h0, ycnt}, wb_dat_i, wb_sel_i);
          next_ycnt = tmp[15:0]; end
        vcd_pkg::A_YMOD: begin tmp = merge({16'h0, ymod}, wb_dat_i, wb_sel_i);
          next_ymod = tmp[15:0]; end
        vcd_pkg::A_NDP: next_ndp = merge(ndp, wb_dat_i, wb_sel_i);
        vcd_pkg::A_STAT: if (wb_sel_i[0])
        begin
          next_done = done & ~wb_dat_i[vcd_pkg::ST_DONE];
          next_ovr = ovr & ~wb_dat_i[vcd_pkg::ST_OVR];
        end
        vcd_pkg::A_PCTL: if (wb_sel_i[0]) next_pctl = wb_dat_i[2:0];
        vcd_pkg::A_PFRM: begin tmp = merge({16'h0, frm}, wb_dat_i, wb_sel_i);
          next_frm = tmp[15:0]; end
        default: tmp = 32'h0;
      endcase
    if (!cfg[vcd_pkg::CFG_EN])
      next_halt = 1'b0;
    unique case (st)
      vcd_pkg::S_IDLE:
        if (cfg[vcd_pkg::CFG_EN] && !halt)
        begin
          if (listed)
          begin
            next_fp = ndp;
            next_elem = 2'h0;
            next_st = vcd_pkg::S_DESC;
          end
          else
          begin
            go = 1'b1;
            next_st = vcd_pkg::S_XFER;
          end
        end
      vcd_pkg::S_DESC:
        if (!m_cyc_o)
        begin
          next_mcyc = 1'b1;
          next_mwe = 1'b0;
          next_madr = {fp[31:2], 2'h0};
          next_msel = fp[1] ? 4'hc : 4'h3;
        end
        else if (m_ack_i)
        begin
          next_mcyc = 1'b0;
          next_fp = fp + 32'h2;
          next_elem = elem + 2'h1;
          unique case (elem)
            2'h0: next_ndp = {ndp[31:16], ev};
            2'h1: next_start = {start[31:16], ev};
            2'h2: next_start = {ev, start[15:0]};
            2'h3: next_cfg = ev;
          endcase
          if ({2'h0, elem} + 4'h1 >= nd)
          begin
            if (elem == 2'h3 && !ev[vcd_pkg::CFG_EN])
              next_st = vcd_pkg::S_IDLE;
            else
            begin
              go = 1'b1;
              next_st = vcd_pkg::S_XFER;
            end
          end
        end
      vcd_pkg::S_XFER:
        if (!m_cyc_o && wpend)
        begin
          next_mcyc = 1'b1;
          next_mwe = 1'b1;
          next_madr = {cur[31:2], 2'h0};
          next_msel = lane_sel(ww, cur[1:0]);
          next_mdat = wdat;
        end
        else if (m_cyc_o && m_ack_i)
        begin
          next_mcyc = 1'b0;
          next_mwe = 1'b0;
          next_wpend = 1'b0;
          if (xcur > 16'h0001)
          begin
            next_xcur = xcur - 16'h0001;
            next_cur = cur_x;
          end
          else if (ycur > 16'h0001)
          begin
            next_ycur = ycur - 16'h0001;
            next_xcur = xcnt;
            next_cur = cur_y;
          end
          else
          begin
            next_done = 1'b1;
            if (listed)
            begin
              next_fp = ndp;
              next_elem = 2'h0;
              next_st = vcd_pkg::S_DESC;
            end
            else
            begin
              next_halt = 1'b1;
              next_st = vcd_pkg::S_IDLE;
            end
          end
        end
      default: next_st = vcd_pkg::S_IDLE;
    endcase
    if (go)
    begin
      next_xcur = next_xcnt;
      next_ycur = next_ycnt;
      next_cur = next_start;
    end
    // disabling stops the channel once the bus is free
    if (!cfg[vcd_pkg::CFG_EN] && !m_cyc_o)
      next_st = vcd_pkg::S_IDLE;
    // bytes gather into words; a word with no room counts as overrun
    if (st == vcd_pkg::S_IDLE || !cfg[vcd_pkg::CFG_DIR])
      next_pcnt = 2'h0;
    else if (pvld)
    begin
      next_pack[{pcnt, 3'h0} +: 8] = pbyte;
      next_pcnt = pcnt + 2'h1;
      if (pcnt == last_byte(ww))
      begin
        next_pcnt = 2'h0;
        if (next_wpend)
          next_ovr = 1'b1;
        else
        begin
          next_wpend = 1'b1;
          next_wdat = ww == vcd_pkg::WW_8 ? {4{next_pack[7:0]}} :
            ww == vcd_pkg::WW_16 ? {2{next_pack[15:0]}} : next_pack;
        end
      end
    end
  end

  // registers of the slave, channel and master
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg <= vcd_pkg::CFG_RST; start <= 32'h0; xcnt <= 16'h0;
      xmod <= 16'h0; ycnt <= 16'h0; ymod <= 16'h0; ndp <= 32'h0;
      fp <= 32'h0; cur <= 32'h0; xcur <= 16'h0; ycur <= 16'h0;
      elem <= 2'h0; pcnt <= 2'h0; pack <= 32'h0; wdat <= 32'h0;
      wpend <= 1'b0; done <= 1'b0; ovr <= 1'b0; halt <= 1'b0;
      pctl <= vcd_pkg::PCTL_RST; frm <= vcd_pkg::FRM_RST;
      st <= vcd_pkg::S_IDLE; m_cyc_o <= 1'b0; m_stb_o <= 1'b0;
      m_we_o <= 1'b0; m_adr_o <= 32'h0; m_sel_o <= 4'h0;
      m_dat_o <= 32'h0; wb_dat_o <= 32'h0; wb_ack_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      cfg <= next_cfg; start <= next_start; xcnt <= next_xcnt;
      xmod <= next_xmod; ycnt <= next_ycnt; ymod <= next_ymod;
      ndp <= next_ndp; fp <= next_fp; cur <= next_cur;
      xcur <= next_xcur; ycur <= next_ycur; elem <= next_elem;
      pcnt <= next_pcnt; pack <= next_pack; wdat <= next_wdat;
      wpend <= next_wpend; done <= next_done; ovr <= next_ovr;
      halt <= next_halt; pctl <= next_pctl; frm <= next_frm;
      st <= next_st; m_cyc_o <= next_mcyc; m_stb_o <= next_mcyc;
      m_we_o <= next_mwe; m_adr_o <= next_madr; m_sel_o <= next_msel;
      m_dat_o <= next_mdat; wb_dat_o <= next_rdat; wb_ack_o <= wr | rd;
      irq_o <= next_done & next_cfg[vcd_pkg::CFG_IE];
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence seq_wr_ack;
    st == vcd_pkg::S_XFER && m_cyc_o && m_ack_i;
  endsequence
  sequence seq_last;
    seq_wr_ack ##0 xcur <= 16'h0001 && ycur <= 16'h0001;
  endsequence

  chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o ##1 !wb_ack_o)
    else $error("register access not answered in one cycle");
  chk_desc_first: assert property (st == vcd_pkg::S_IDLE && listed
    && cfg[vcd_pkg::CFG_EN] && !halt |=> st == vcd_pkg::S_DESC
    ##1 m_cyc_o && !m_we_o)
    else $error("enable did not start a descriptor fetch");
  chk_elem_ptr: assert property (st == vcd_pkg::S_DESC && m_cyc_o
    && m_ack_i && elem == 2'h0 |=> ndp[15:0] == $past(ev))
    else $error("first element not taken as pointer");
  chk_cfg_load: assert property (st == vcd_pkg::S_DESC && m_cyc_o
    && m_ack_i && elem == 2'h3 |=> cfg == $past(ev))
    else $error("fourth element not taken as configuration");
  chk_stride: assert property (seq_wr_ack ##0 xcur > 16'h0001
    |=> cur == $past(cur_x))
    else $error("address did not step by the inner stride");
  chk_row_wrap: assert property (seq_wr_ack ##0 xcur <= 16'h0001
    && ycur > 16'h0001 |=> xcur == xcnt
    && ycur == $past(ycur) - 16'h0001)
    else $error("row end did not reload the inner count");
  chk_irq: assert property (seq_last ##0 cfg[vcd_pkg::CFG_IE]
    |=> done && irq_o)
    else $error("finished buffer raised no interrupt");
  chk_follow: assert property (seq_last ##0 listed
    |=> st == vcd_pkg::S_DESC && fp == $past(ndp))
    else $error("chain not followed to the next descriptor");
  chk_lanes: assert property (m_cyc_o && m_we_o && !m_ack_i
    |=> m_sel_o == $past(m_sel_o) && m_adr_o == $past(m_adr_o))
    else $error("memory write changed while waiting");
endmodule
`default_nettype wire

//--- testbench/vcd_decoder_model.sv
`timescale 1ns/1ps
`default_nettype none
module vcd_decoder_model (
  // decoder pins
  output logic vid_clk_o,
  output logic [7:0] vid_data_o
);
  // clock rests low outside bursts
  initial
  begin
    vid_clk_o = 1'b0;
    vid_data_o = 8'h5a;
  end
  task automatic send_byte(input logic [7:0] b);
    vid_data_o = b;
    #160 vid_clk_o = 1'b1;
    #160 vid_clk_o = 1'b0;
  endtask
  // released data must not look like the last byte
  task automatic rest();
    vid_data_o = ~vid_data_o;
  endtask
  // two fields a frame, field one first; lines cut short
  task automatic send_frame();
    for (int f = 0; f < 2; f++)
    begin
      for (int l = 0; l < 2; l++)
      begin
        send_byte(8'hff);
        send_byte(8'h00);
        send_byte(8'h00);
        send_byte(f ? 8'hd0 : 8'h90);
        send_byte(8'h80);
        send_byte(8'h80);
      end
    end
  endtask
endmodule
`default_nettype wire

//--- testbench/vcd_dma_tb.sv
`timescale 1ns/1ps
`default_nettype none
module vcd_dma_tb;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic m_cyc_o, m_stb_o, m_we_o, m_ack_i, vid_clk, irq_o, slow, hold;
  logic [7:0] wb_adr_i, vid_data;
  logic [3:0] wb_sel_i, m_sel_o;
  logic [31:0] wb_dat_i, wb_dat_o, m_adr_o, m_dat_o, m_dat_i, rd;
  logic [15:0] dm [int];
  logic [68:0] mlog [$];
  logic [68:0] exp_q [$];
  int failures, num_checks;
  vcd_decoder_model dec_u (.vid_clk_o(vid_clk), .vid_data_o(vid_data));
  vcd_dma dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .m_cyc_o(m_cyc_o), .m_stb_o(m_stb_o),
    .m_we_o(m_we_o), .m_adr_o(m_adr_o), .m_sel_o(m_sel_o),
    .m_dat_o(m_dat_o), .m_ack_i(m_ack_i), .m_dat_i(m_dat_i),
    .vid_clk_i(vid_clk), .vid_data_i(vid_data), .irq_o(irq_o));
  // system clock
  initial
  begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // memory slave; every other access is slow, each access is logged
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      m_ack_i <= 1'b0;
      m_dat_i <= 32'h0;
      slow <= 1'b0;
      hold <= 1'b0;
    end
    else if (m_ack_i)
    begin
      m_ack_i <= 1'b0;
      m_dat_i <= ~m_dat_i;
      mlog.push_back({m_we_o, m_adr_o, m_sel_o, m_we_o ? m_dat_o : 32'h0});
    end
    else if (m_cyc_o && m_stb_o)
    begin
      hold <= slow && !hold;
      if (!slow || hold)
      begin
        m_ack_i <= 1'b1;
        slow <= ~slow;
        // only descriptor reads look up memory; writes need no data
        if (!m_we_o)
          m_dat_i <= {2{dm[int'(m_adr_o + (m_sel_o[2] ? 32'h2 : 32'h0))]}};
      end
    end
  end
  // verdict and end of run
  task automatic wrap_up();
    if (failures == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // compare register values
  task automatic chk_reg(input string what, input logic [31:0] e,
                         input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // compare memory accesses
  task automatic chk_mem(input logic [68:0] e, input logic [68:0] g);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("CHECK FAILED mem access expected %h seen %h", e, g);
    end
  endtask
  // classic wishbone cycle, result left in rd
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      failures++;
      wrap_up();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  // bounded wait for logged memory accesses
  task automatic wait_log(input int n);
    int k;
    k = 0;
    while (mlog.size() < n && k < 2000)
    begin
      @(posedge clk_i);
      k++;
    end
    // the log grows at the launching edge; let outputs settle first
    @(posedge clk_i);
    if (k >= 2000)
    begin
      failures++;
      wrap_up();
    end
  endtask
  // bursts off the clock phase, then settle through the synchroniser
  task automatic bytes(input logic [7:0] s, input int n);
    #13;
    for (int i = 0; i < n; i++)
      dec_u.send_byte(s + 8'(i));
    dec_u.rest();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic frames(input int n);
    #13;
    repeat (n) dec_u.send_frame();
    dec_u.rest();
    repeat (4) @(posedge clk_i);
  endtask
  task automatic exp_desc(input logic [31:0] b);
    exp_q.push_back({1'b0, b, 4'h3, 32'h0});
    exp_q.push_back({1'b0, b, 4'hc, 32'h0});
    exp_q.push_back({1'b0, b + 32'h4, 4'h3, 32'h0});
    exp_q.push_back({1'b0, b + 32'h4, 4'hc, 32'h0});
  endtask
  // main sequence
  initial
  begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {12'hf, 32'h0};
    {failures, num_checks} = '0;
    dm[32'h100] = 16'h0110;
    dm[32'h102] = 16'h1000;
    dm[32'h104] = 16'h0000;
    dm[32'h106] = 16'h3465;
    dm[32'h110] = 16'h0100;
    dm[32'h112] = 16'h2000;
    dm[32'h114] = 16'h0000;
    dm[32'h116] = 16'h3461;
    exp_desc(32'h100);
    for (int k = 0; k < 4; k++)
      exp_q.push_back({1'b1, 32'h1000 + 32'(4 * k), 4'hf, 8'(19 + 4 * k),
        8'(18 + 4 * k), 8'(17 + 4 * k), 8'(16 + 4 * k)});
    exp_desc(32'h110);
    for (int k = 0; k < 4; k++)
      exp_q.push_back({1'b1, 32'h2000 + 32'(4 * k), 4'h1, {4{8'(32 + k)}}});
    exp_desc(32'h100);
    for (int k = 0; k < 4; k++)
      exp_q.push_back({1'b1, 32'h1000 + 32'(4 * k), 4'h3,
        {2{8'(49 + 2 * k), 8'(48 + 2 * k)}}});
    exp_desc(32'h110);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, vcd_pkg::A_PFRM, 32'h0);
    chk_reg("frame lines", 32'h20d, rd);
    wb(1'b0, vcd_pkg::A_PSTAT, 32'h0);
    chk_reg("serving channel", 32'h0, 32'(rd[7:4]));
    wb(1'b0, 8'h40, 32'h0);
    chk_reg("unmapped", 32'h0, rd);
    wb(1'b1, vcd_pkg::A_PCTL, 32'h1);
    wb(1'b1, vcd_pkg::A_XCNT, 32'h2);
    wb(1'b1, vcd_pkg::A_YCNT, 32'h2);
    wb(1'b1, vcd_pkg::A_XMOD, 32'h4);
    wb(1'b1, vcd_pkg::A_YMOD, 32'h4);
    wb(1'b1, vcd_pkg::A_NDP, 32'h100);
    wb(1'b1, vcd_pkg::A_CFG, 32'h3465);
    wait_log(4);
    // the refetched first descriptor then asks for halfwords
    dm[32'h106] = 16'h3463;
    bytes(8'h10, 16);
    wait_log(8);
    chk_reg("irq", 32'h1, 32'(irq_o));
    wb(1'b0, vcd_pkg::A_STAT, 32'h0);
    chk_reg("done", 32'h1, 32'(rd[0]));
    wb(1'b1, vcd_pkg::A_STAT, 32'h1);
    repeat (2) @(posedge clk_i);
    chk_reg("irq cleared", 32'h0, 32'(irq_o));
    wait_log(12);
    bytes(8'h20, 4);
    wait_log(20);
    bytes(8'h30, 8);
    wait_log(28);
    wb(1'b1, vcd_pkg::A_CFG, 32'h0);
    for (int i = 0; i < 28; i++)
      chk_mem(exp_q[i], mlog[i]);
    // embedded code framing with matching and short frame length
    wb(1'b1, vcd_pkg::A_PCTL, 32'h3);
    wb(1'b1, vcd_pkg::A_PFRM, 32'h4);
    frames(3);
    wb(1'b0, vcd_pkg::A_PSTAT, 32'h0);
    chk_reg("track error clear", 32'h0, 32'(rd[0]));
    wb(1'b1, vcd_pkg::A_PFRM, 32'h3);
    frames(2);
    wb(1'b0, vcd_pkg::A_PSTAT, 32'h0);
    chk_reg("track error set", 32'h1, 32'(rd[0]));
    frames(1);
    wb(1'b0, vcd_pkg::A_PSTAT, 32'h0);
    chk_reg("track error held", 32'h1, 32'(rd[0]));
    wb(1'b1, vcd_pkg::A_PSTAT, 32'h1);
    wb(1'b0, vcd_pkg::A_PSTAT, 32'h0);
    chk_reg("track error cleared", 32'h0, 32'(rd[0]));
    wrap_up();
  end
endmodule
`default_nettype wire
